// ===== nfcw_consts.vh
/*
 * Constants for the NAND feature-configuration host controller.
 * Assumes a single 250 MHz system clock and an asynchronous NAND device on pins.
 */
`ifndef NFCW_CONSTS_VH
`define NFCW_CONSTS_VH

// Device command codes.
`define NFCW_CMD_SETF        8'h_EF
`define NFCW_CMD_GETF        8'h_EE
`define NFCW_CMD_STATUS      8'h_70
`define NFCW_CMD_READ        8'h_00
`define NFCW_CMD_RESET       8'h_FF

// Device feature addresses and field layout.
`define NFCW_FA_DRIVE        8'h_80
`define NFCW_FA_PULLDN       8'h_81
`define NFCW_STRENGTH_MASK   8'h_03
`define NFCW_PARAM_LAST      2'h_3
`define NFCW_STATUS_RDY_BIT  5

// Controller register map (word indices on the local port).
`define NFCW_REG_CTRL        4'h_0
`define NFCW_REG_FADDR       4'h_1
`define NFCW_REG_WDATA       4'h_2
`define NFCW_REG_RDATA       4'h_3
`define NFCW_REG_STATUS      4'h_4
`define NFCW_REG_BUSYTMO     4'h_5

// Control register command field values.
`define NFCW_OP_SET          2'h_1
`define NFCW_OP_GET          2'h_2
`define NFCW_OP_RESET        2'h_3

// Pin timing: half a write/read cycle is 16 ns, held as ns and derived cycles.
`define NFCW_T_PHASE_NS      16
`define NFCW_CLK_NS          4
// Rounded up to whole clocks and sized to the 8-bit phase counter.
`define NFCW_T_PHASE_CYC     8'h_04
// Address-to-data gap of 70 ns.
`define NFCW_T_ADL_NS        70
`define NFCW_T_ADL_CYC       8'h_12
// Write-protect setup of 100 ns before the first command.
`define NFCW_T_WW_NS         100
`define NFCW_T_WW_CYC        8'h_19

`define NFCW_RST_VAL         8'h_00
`define NFCW_BUSYTMO_RST     16'h_FFFF

`endif

// ===== nfcw_host.v
/*
 * Host controller that drives a NAND device's feature commands over its pins.
 * Assumes software on a simple strobe port and device pins outside this clock domain.
 */
`timescale 1ns/100ps
`include "nfcw_consts.vh"

module nfcw_host (
	input  wire        CLK_SYS_IN,
	input  wire        RSTN_IN,
	input  wire        CE_IN,
	input  wire [3:0]  ADDR_IN,
	input  wire [31:0] WDATA_IN,
	input  wire        WR_IN,
	input  wire        RD_IN,
	output reg  [31:0] RDATA_OUT,
	output reg         NAND_CE_N_OUT,
	output reg         NAND_CLE_OUT,
	output reg         NAND_ALE_OUT,
	output reg         NAND_WE_N_OUT,
	output reg         NAND_RE_N_OUT,
	output reg         NAND_WP_N_OUT,
	output reg  [7:0]  NAND_IO_OUT,
	output reg         NAND_IO_OE_OUT,
	input  wire [7:0]  NAND_IO_IN,
	input  wire        NAND_RB_N_IN
);

	localparam [3:0] ST_IDLE = 4'h_0;
	localparam [3:0] ST_WP   = 4'h_1;
	localparam [3:0] ST_CMD  = 4'h_2;
	localparam [3:0] ST_ADR  = 4'h_3;
	localparam [3:0] ST_ADL  = 4'h_4;
	localparam [3:0] ST_WDAT = 4'h_5;
	localparam [3:0] ST_BUSY = 4'h_6;
	localparam [3:0] ST_POLL = 4'h_7;
	localparam [3:0] ST_PRD  = 4'h_8;
	localparam [3:0] ST_RCMD = 4'h_9;
	localparam [3:0] ST_RDAT = 4'h_A;
	localparam [3:0] ST_DONE = 4'h_B;

	reg [3:0]  state;
	reg [1:0]  op;
	reg [7:0]  faddr;
	reg [31:0] wparams;
	reg [31:0] rparams;
	reg [1:0]  idx;
	reg        phase;
	reg [7:0]  tcnt;
	reg [15:0] busy_tmo;
	reg [15:0] busy_cnt;
	reg        wp_en;
	reg        poll_mode;
	reg        timeout;
	reg        busy_seen;
	reg [2:0]  rb_sync;
	reg [7:0]  io_s1;
	reg [7:0]  io_s2;
	reg [7:0]  io_s3;
	reg [7:0]  io_stable;
	reg        rb_stable;
	reg [7:0]  status_byte;

	// Strength field extractor shared by both feature addresses.
	function [7:0] strength;
		input [7:0] b;
		begin
			strength = b & `NFCW_STRENGTH_MASK;
		end
	endfunction

	// Busy and data pins pass three flops; a change counts once the last two agree.
	always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rb_sync   <= 3'h_7;
			rb_stable <= 1'b1;
			io_s1     <= `NFCW_RST_VAL;
			io_s2     <= `NFCW_RST_VAL;
			io_s3     <= `NFCW_RST_VAL;
			io_stable <= `NFCW_RST_VAL;
		end else if (CE_IN) begin
			rb_sync <= {rb_sync[1:0], NAND_RB_N_IN};
			io_s1   <= NAND_IO_IN;
			io_s2   <= io_s1;
			io_s3   <= io_s2;
			if (rb_sync[2] == rb_sync[1])
				rb_stable <= rb_sync[2];
			// The byte is only taken once it has held for two samples.
			if (io_s3 == io_s2)
				io_stable <= io_s3;
		end
	end

	wire busy_n = rb_stable;
	wire start  = WR_IN && (ADDR_IN == `NFCW_REG_CTRL) && (state == ST_IDLE);
	// Reserved feature addresses are sent as given; only 80h/81h get field masking.
	wire known_fa = (faddr == `NFCW_FA_DRIVE) || (faddr == `NFCW_FA_PULLDN);

	// Main sequencer: one write or read pin cycle is two timed phases.
	always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state          <= ST_IDLE;
			op             <= 2'h_0;
			faddr          <= `NFCW_RST_VAL;
			wparams        <= 32'h_0000_0000;
			rparams        <= 32'h_0000_0000;
			idx            <= 2'h_0;
			phase          <= 1'b0;
			tcnt           <= 8'h_00;
			busy_tmo       <= `NFCW_BUSYTMO_RST;
			busy_cnt       <= 16'h_0000;
			wp_en          <= 1'b0;
			poll_mode      <= 1'b0;
			timeout        <= 1'b0;
			busy_seen      <= 1'b0;
			status_byte    <= `NFCW_RST_VAL;
			RDATA_OUT      <= 32'h_0000_0000;
			NAND_CE_N_OUT  <= 1'b1;
			NAND_CLE_OUT   <= 1'b0;
			NAND_ALE_OUT   <= 1'b0;
			NAND_WE_N_OUT  <= 1'b1;
			NAND_RE_N_OUT  <= 1'b1;
			NAND_WP_N_OUT  <= 1'b0;
			NAND_IO_OUT    <= `NFCW_RST_VAL;
			NAND_IO_OE_OUT <= 1'b0;
		end else if (CE_IN) begin
			// Register reads answer one cycle after the strobe.
			RDATA_OUT <= 32'h_0000_0000;
			if (RD_IN) begin
				case (ADDR_IN)
				`NFCW_REG_CTRL:    RDATA_OUT <= {29'h_0000_0000, poll_mode, op};
				`NFCW_REG_FADDR:   RDATA_OUT <= {24'h_00_0000, faddr};
				`NFCW_REG_WDATA:   RDATA_OUT <= wparams;
				`NFCW_REG_RDATA:   RDATA_OUT <= rparams;
				`NFCW_REG_STATUS:  RDATA_OUT <= {16'h_0000, status_byte, 4'h_0,
					busy_n, timeout, wp_en, (state != ST_IDLE)};
				`NFCW_REG_BUSYTMO: RDATA_OUT <= {16'h_0000, busy_tmo};
				default:           RDATA_OUT <= 32'h_0000_0000;
				endcase
			end
			// Configuration writes are ignored while an operation runs.
			if (WR_IN && state == ST_IDLE) begin
				case (ADDR_IN)
				`NFCW_REG_FADDR:   faddr <= WDATA_IN[7:0];
				`NFCW_REG_WDATA:   wparams <= WDATA_IN;
				`NFCW_REG_BUSYTMO: busy_tmo <= WDATA_IN[15:0];
				`NFCW_REG_STATUS:  wp_en <= WDATA_IN[1];
				default:           ;
				endcase
			end
			if (start) begin
				op        <= WDATA_IN[1:0];
				poll_mode <= WDATA_IN[2];
				timeout   <= 1'b0;
				tcnt      <= 8'h_00;
				NAND_CE_N_OUT <= 1'b0;
				// Protect pin settles before the first command, held until done.
				NAND_WP_N_OUT <= wp_en;
				state     <= ST_WP;
			end
			if (tcnt != 8'h_00)
				tcnt <= tcnt - 8'h_01;
			else begin
				case (state)
				ST_IDLE: ;
				ST_WP: begin
					tcnt  <= `NFCW_T_WW_CYC;
					phase <= 1'b0;
					state <= ST_CMD;
				end
				ST_CMD: begin
					// Two-phase command write: strobe low, then rising edge latches.
					if (!phase) begin
						NAND_CLE_OUT   <= 1'b1;
						NAND_WE_N_OUT  <= 1'b0;
						NAND_IO_OE_OUT <= 1'b1;
						case (op)
						`NFCW_OP_SET: NAND_IO_OUT <= `NFCW_CMD_SETF;
						`NFCW_OP_GET: NAND_IO_OUT <= `NFCW_CMD_GETF;
						default:      NAND_IO_OUT <= `NFCW_CMD_RESET;
						endcase
						phase <= 1'b1;
					end else begin
						NAND_WE_N_OUT <= 1'b1;
						phase <= 1'b0;
						busy_cnt <= 16'h_0000;
						busy_seen <= 1'b0;
						state <= (op == `NFCW_OP_RESET) ? ST_BUSY : ST_ADR;
					end
					tcnt <= `NFCW_T_PHASE_CYC;
				end
				ST_ADR: begin
					// Exactly one address cycle with the feature address.
					if (!phase) begin
						NAND_CLE_OUT  <= 1'b0;
						NAND_ALE_OUT  <= 1'b1;
						NAND_WE_N_OUT <= 1'b0;
						NAND_IO_OUT   <= faddr;
						phase <= 1'b1;
						tcnt  <= `NFCW_T_PHASE_CYC;
					end else begin
						NAND_WE_N_OUT <= 1'b1;
						phase <= 1'b0;
						idx   <= 2'h_0;
						if (op == `NFCW_OP_SET) begin
							tcnt  <= `NFCW_T_ADL_CYC;
							state <= ST_ADL;
						end else begin
							tcnt  <= `NFCW_T_PHASE_CYC;
							state <= ST_BUSY;
						end
					end
				end
				ST_ADL: begin
					NAND_ALE_OUT <= 1'b0;
					state <= ST_WDAT;
				end
				ST_WDAT: begin
					// Four parameter bytes, first to fourth, one per rising strobe.
					if (!phase) begin
						NAND_WE_N_OUT <= 1'b0;
						NAND_IO_OUT <= (known_fa && idx == 2'h_0) ? strength(wparams[7:0]) :
							known_fa ? `NFCW_RST_VAL : wparams[8*idx +: 8];
						phase <= 1'b1;
					end else begin
						NAND_WE_N_OUT <= 1'b1;
						phase <= 1'b0;
						idx   <= idx + 2'h_1;
						if (idx == `NFCW_PARAM_LAST) begin
							busy_cnt  <= 16'h_0000;
							busy_seen <= 1'b0;
							state <= ST_BUSY;
						end
					end
					tcnt <= `NFCW_T_PHASE_CYC;
				end
				ST_BUSY: begin
					// Wait for busy then ready with no command meanwhile; in poll mode a get or set goes to status polling at once.
					// Latch levels are let go a phase after the last strobe rose, never with it.
					NAND_CLE_OUT   <= 1'b0;
					NAND_ALE_OUT   <= 1'b0;
					NAND_IO_OE_OUT <= 1'b0;
					busy_cnt <= busy_cnt + 16'h_0001;
					if (!busy_n)
						busy_seen <= 1'b1;
					if (poll_mode && op != `NFCW_OP_RESET) begin
						phase <= 1'b0;
						state <= ST_POLL;
					end else if (busy_seen && busy_n) begin
						state <= (op == `NFCW_OP_GET) ? ST_RDAT : ST_DONE;
					end else if (busy_cnt == busy_tmo) begin
						timeout <= 1'b1;
						state <= ST_DONE;
					end
				end
				ST_POLL: begin
					// Status command write, then one status byte read.
					if (!phase) begin
						NAND_CLE_OUT   <= 1'b1;
						NAND_WE_N_OUT  <= 1'b0;
						NAND_IO_OE_OUT <= 1'b1;
						NAND_IO_OUT    <= `NFCW_CMD_STATUS;
						phase <= 1'b1;
					end else begin
						NAND_WE_N_OUT  <= 1'b1;
						phase <= 1'b0;
						state <= ST_PRD;
					end
					tcnt <= `NFCW_T_PHASE_CYC;
				end
				ST_PRD: begin
					if (!phase) begin
						// Command latch and data drive end here, after the hold phase.
						NAND_CLE_OUT   <= 1'b0;
						NAND_IO_OE_OUT <= 1'b0;
						NAND_RE_N_OUT <= 1'b0;
						phase <= 1'b1;
						tcnt  <= `NFCW_T_PHASE_CYC;
					end else begin
						NAND_RE_N_OUT <= 1'b1;
						status_byte <= io_stable;
						phase <= 1'b0;
						busy_cnt <= busy_cnt + 16'h_0001;
						if (io_stable[`NFCW_STATUS_RDY_BIT])
							state <= (op == `NFCW_OP_GET) ? ST_RCMD : ST_DONE;
						else if (busy_cnt >= busy_tmo) begin
							timeout <= 1'b1;
							state <= ST_DONE;
						end else
							state <= ST_POLL;
						tcnt <= `NFCW_T_PHASE_CYC;
					end
				end
				ST_RCMD: begin
					// Read command restores data output after status polling.
					if (!phase) begin
						NAND_CLE_OUT   <= 1'b1;
						NAND_WE_N_OUT  <= 1'b0;
						NAND_IO_OE_OUT <= 1'b1;
						NAND_IO_OUT    <= `NFCW_CMD_READ;
						phase <= 1'b1;
					end else begin
						NAND_WE_N_OUT  <= 1'b1;
						phase <= 1'b0;
						state <= ST_RDAT;
					end
					tcnt <= `NFCW_T_PHASE_CYC;
				end
				ST_RDAT: begin
					// Sample at the end of the low phase, through the pin synchroniser.
					if (!phase) begin
						NAND_CLE_OUT   <= 1'b0;
						NAND_IO_OE_OUT <= 1'b0;
						NAND_RE_N_OUT <= 1'b0;
						phase <= 1'b1;
					end else begin
						NAND_RE_N_OUT <= 1'b1;
						rparams[8*idx +: 8] <= io_stable;
						phase <= 1'b0;
						idx   <= idx + 2'h_1;
						if (idx == `NFCW_PARAM_LAST)
							state <= ST_DONE;
					end
					tcnt <= `NFCW_T_PHASE_CYC;
				end
				ST_DONE: begin
					// Device stays in feature mode; the controller just releases the bus.
					NAND_CE_N_OUT  <= 1'b1;
					NAND_CLE_OUT   <= 1'b0;
					NAND_ALE_OUT   <= 1'b0;
					NAND_IO_OE_OUT <= 1'b0;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

// ===== nfcw_host_assertions.sv
/* Checker for the feature-command host: pin sequencing and write-protect hold.
   Assumes it is bound to nfcw_host and sees only that module's ports. */
`timescale 1ns/100ps
module nfcw_host_chk (
	input wire       CLK_SYS_IN,
	input wire       RSTN_IN,
	input wire       NAND_CE_N_OUT,
	input wire       NAND_CLE_OUT,
	input wire       NAND_ALE_OUT,
	input wire       NAND_WE_N_OUT,
	input wire       NAND_RE_N_OUT,
	input wire       NAND_WP_N_OUT,
	input wire [7:0] NAND_IO_OUT,
	input wire       NAND_RB_N_IN
);
	reg [2:0] n_adr;
	reg [2:0] n_dat;
	reg       stat_pend;
	reg       re_seen;

	// Tallies per operation; a deselected chip starts the next one clean.
	always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN || NAND_CE_N_OUT) begin
			n_adr     <= 3'h0;
			n_dat     <= 3'h0;
			stat_pend <= 1'b0;
			re_seen   <= 1'b0;
		end else if ($rose(NAND_WE_N_OUT) && NAND_CLE_OUT) begin
			stat_pend <= (NAND_IO_OUT == 8'h70);
			re_seen   <= 1'b0;
		end else if ($rose(NAND_WE_N_OUT)) begin
			n_adr <= n_adr + {2'h0, NAND_ALE_OUT};
			n_dat <= n_dat + {2'h0, !NAND_ALE_OUT};
		end else if ($rose(NAND_RE_N_OUT)) begin
			re_seen <= 1'b1;
		end
	end

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RSTN_IN);

	// A command latch and the address strobe that must follow it.
	sequence cmd_latch(logic [7:0] code);
		$rose(NAND_WE_N_OUT) && NAND_CLE_OUT && NAND_IO_OUT == code;
	endsequence
	sequence addr_start;
		##[1:12] ($fell(NAND_WE_N_OUT) && NAND_ALE_OUT);
	endsequence

	a_set_cmd_addr: assert property (cmd_latch(8'hEF) |-> addr_start)
		else $error("set command without address cycle");
	a_get_cmd_addr: assert property (cmd_latch(8'hEE) |-> addr_start)
		else $error("get command without address cycle");
	a_one_addr: assert property ($rose(NAND_WE_N_OUT) && NAND_ALE_OUT |-> n_adr == 3'h0)
		else $error("second address cycle in one operation");
	a_four_params: assert property ($rose(NAND_CE_N_OUT) |-> n_dat == 3'h0 || n_dat == 3'h4)
		else $error("parameter byte count is not four");
	a_read_after_stat: assert property ($fell(NAND_RE_N_OUT) && stat_pend |-> !re_seen)
		else $error("data read after status without read command");
	a_wp_steady: assert property (!NAND_CE_N_OUT && !$past(NAND_CE_N_OUT) |-> $stable(NAND_WP_N_OUT))
		else $error("write protect moved during an operation");
	a_busy_quiet: assert property ($rose(NAND_WE_N_OUT) && !$past(NAND_RB_N_IN)
		|-> NAND_CLE_OUT && NAND_IO_OUT == 8'h70)
		else $error("strobe other than status while busy");
endmodule

bind nfcw_host nfcw_host_chk u_chk (
	.CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN), .NAND_CE_N_OUT(NAND_CE_N_OUT),
	.NAND_CLE_OUT(NAND_CLE_OUT), .NAND_ALE_OUT(NAND_ALE_OUT), .NAND_WE_N_OUT(NAND_WE_N_OUT),
	.NAND_RE_N_OUT(NAND_RE_N_OUT), .NAND_WP_N_OUT(NAND_WP_N_OUT),
	.NAND_IO_OUT(NAND_IO_OUT), .NAND_RB_N_IN(NAND_RB_N_IN)
);

// ===== nfcw_dev_model.sv
/* Behavioural flash device: feature commands, status, reset, busy window.
   Assumes the bench merges both drivers of the data pins. */
`timescale 1ns/100ps
module nfcw_dev_model (
	input  wire        ce_n_in,
	input  wire        cle_in,
	input  wire        ale_in,
	input  wire        we_n_in,
	input  wire        re_n_in,
	input  wire        wp_n_in,
	input  wire [7:0]  io_in,
	input  wire [15:0] busy_ns_in,
	output wire [7:0]  io_out,
	output reg         rb_n_out
);
	reg [7:0]  cmd;
	reg [7:0]  fa;
	reg [31:0] drive;
	reg [31:0] pulldn;
	reg [31:0] word;
	reg [7:0]  prm [0:3];
	reg [1:0]  wn;
	reg [1:0]  rn;
	reg        stat;
	wire [7:0] q;
	event      go;

	// Power-on defaults; only a new run clears the stored strengths.
	initial begin
		drive    = 32'h0000_0000;
		pulldn   = 32'h0000_0000;
		rb_n_out = 1'b1;
		stat     = 1'b0;
		cmd      = 8'h00;
	end
	// Busy window; a trigger while already busy is absorbed.
	always @(go) begin
		rb_n_out = 1'b0;
		#(busy_ns_in);
		rb_n_out = 1'b1;
	end
	// Command, address and parameter cycles latch on the write strobe's rise.
	always @(posedge we_n_in) begin
		if (!ce_n_in && cle_in) begin
			stat = (io_in == 8'h70);
			if (io_in != 8'h70 && io_in != 8'h00) cmd = io_in;
			if (io_in == 8'hFF) -> go;
		end else if (!ce_n_in && ale_in) begin
			fa     = io_in;
			wn     = 2'h0;
			rn     = 2'h0;
			// Reserved places read back as zero whatever was written to them.
			word = (fa == 8'h80) ? drive : 32'h0000_0000;
			if (fa == 8'h81) word = pulldn;
			prm[0] = word[7:0];
			prm[1] = word[15:8];
			prm[2] = word[23:16];
			prm[3] = word[31:24];
			if (cmd == 8'hEE) -> go;
		end else if (!ce_n_in && cmd == 8'hEF) begin
			prm[wn] = io_in;
			wn      = wn + 2'h1;
			// All four bytes are kept, so a reserved bit the host failed to clear reads back.
			if (wn == 2'h0 && fa == 8'h80) drive = {prm[3], prm[2], prm[1], prm[0]};
			if (wn == 2'h0 && fa == 8'h81) pulldn = {prm[3], prm[2], prm[1], prm[0]};
			if (wn == 2'h0) -> go;
		end
	end
	// The read pointer steps as each data read strobe ends; status reads leave it.
	always @(posedge re_n_in) begin
		if (!ce_n_in && !stat) rn = rn + 2'h1;
	end
	// Status shows protect and ready; a released bus shows the inverted byte, not a hold.
	assign q      = stat ? {wp_n_in, rb_n_out, rb_n_out, 5'h00} : prm[rn];
	assign io_out = (!ce_n_in && !re_n_in) ? q : ~q;
endmodule

// ===== tb_top.sv
/* Self-checking bench: host controller driving the device model.
   Assumes the host, its checker and the model are compiled first. */
`timescale 1ns/100ps
module tb_top;
	reg         clk;
	reg         rstn;
	reg         ce;
	reg  [3:0]  addr;
	reg  [31:0] wdata;
	reg         wr_s;
	reg         rd_s;
	reg         rd_d;
	reg  [15:0] busy_ns;
	reg  [63:0] note;
	reg  [63:0] notes [$];
	wire [31:0] rdata;
	wire        ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
	wire [7:0]  io_h;
	wire [7:0]  io_d;
	wire [7:0]  io_bus = oe ? io_h : io_d;
	integer     n_mismatch, compares, cyc, seed, i, s;

	nfcw_host DUT (
		.CLK_SYS_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .NAND_CE_N_OUT(ce_n),
		.NAND_CLE_OUT(cle), .NAND_ALE_OUT(ale), .NAND_WE_N_OUT(we_n), .NAND_RE_N_OUT(re_n),
		.NAND_WP_N_OUT(wp_n), .NAND_IO_OUT(io_h), .NAND_IO_OE_OUT(oe), .NAND_IO_IN(io_bus),
		.NAND_RB_N_IN(rb_n)
	);
	nfcw_dev_model dev (
		.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n), .re_n_in(re_n),
		.wp_n_in(wp_n), .io_in(io_bus), .busy_ns_in(busy_ns), .io_out(io_d), .rb_n_out(rb_n)
	);

	// A 4 ns system clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task close_out;
		begin
			if (n_mismatch == 0 && compares > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask

	// Each read answer meets the oldest note; status polls leave none. Also cuts a hang.
	always @(posedge clk) begin
		if (rd_d && notes.size() > 0) begin
			note     = notes.pop_front();
			compares = compares + 1;
			if ((rdata & note[63:32]) !== note[31:0]) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD t=%0t got %h exp %h", $time, rdata & note[63:32], note[31:0]);
			end
		end
		rd_d <= rd_s;
		cyc = cyc + 1;
		if (cyc == 60000) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD t=%0t got %h exp %h", $time, cyc, 0);
			close_out;
		end
	end

	task reg_wr(input [3:0] a, input [31:0] d);
		begin
			addr  <= a;
			wdata <= d;
			wr_s  <= 1'b1;
			@(posedge clk);
			wr_s <= 1'b0;
			@(posedge clk);
		end
	endtask
	task reg_rd(input [3:0] a, input [31:0] m, input [31:0] e);
		begin
			notes.push_back({m, e});
			addr <= a;
			rd_s <= 1'b1;
			@(posedge clk);
			rd_s <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Polls the active flag; the extra edge keeps the last poll off the note queue.
	task wait_idle;
		integer k;
		reg     busy;
		begin
			busy = 1'b1;
			for (k = 0; k < 2000 && busy; k = k + 1) begin
				addr <= 4'h4;
				rd_s <= 1'b1;
				@(posedge clk);
				rd_s <= 1'b0;
				#1 busy = (rdata[0] !== 1'b0);
				@(posedge clk);
			end
			@(posedge clk);
			if (busy) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD t=%0t got %h exp %h", $time, 1'b1, 1'b0);
			end
		end
	endtask
	task feat(input [1:0] o, input p, input [7:0] fa, input [31:0] d);
		begin
			reg_wr(4'h1, {24'h00_0000, fa});
			reg_wr(4'h2, d);
			reg_wr(4'h0, {29'h0, p, o});
			wait_idle;
		end
	endtask

	// Main sequence: defaults, every strength code, reserved places, reset command.
	initial begin
		n_mismatch = 0;
		compares   = 0;
		cyc        = 0;
		seed       = 21;
		rd_d       = 1'b0;
		rstn    <= 1'b0;
		ce      <= 1'b1;
		addr    <= 4'h0;
		wdata   <= 32'h0000_0000;
		wr_s    <= 1'b0;
		rd_s    <= 1'b0;
		busy_ns <= 16'h00C8;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		reg_rd(4'h5, 32'hFFFF_FFFF, 32'h0000_FFFF);
		reg_rd(4'h9, 32'hFFFF_FFFF, 32'h0000_0000);
		feat(2'h2, 1'b0, 8'h80, 32'h0000_0000);
		reg_rd(4'h3, 32'hFFFF_FFFF, 32'h0000_0000);
		for (i = 0; i < 8; i = i + 1) begin
			s = $random(seed);
			busy_ns <= i[0] ? 16'h0014 : 16'h07D0;
			reg_wr(4'h4, {30'h0, i[0], 1'b0});
			feat(2'h1, i[0], 8'h80 + i[2], {s[31:2], i[1:0]});
			feat(2'h2, ~i[0], 8'h80 + i[2], 32'h0000_0000);
			reg_rd(4'h3, 32'hFFFF_FFFF, {30'h0, i[1:0]});
		end
		for (i = 0; i < 2; i = i + 1) begin
			s = $random(seed);
			feat(2'h1, 1'b0, {i[0], s[6:0]} | 8'h02, s);
			feat(2'h2, 1'b1, {i[0], s[6:0]} | 8'h02, 32'h0000_0000);
			reg_rd(4'h3, 32'hFFFF_FFFF, 32'h0000_0000);
		end
		feat(2'h3, 1'b0, 8'h00, 32'h0000_0000);
		feat(2'h2, 1'b0, 8'h81, 32'h0000_0000);
		reg_rd(4'h3, 32'hFFFF_FFFF, 32'h0000_0003);
		feat(2'h2, 1'b1, 8'h80, 32'h0000_0000);
		reg_rd(4'h3, 32'hFFFF_FFFF, 32'h0000_0003);
		reg_rd(4'h4, 32'h0000_FF0F, 32'h0000_E00A);
		// A write while the clock enable is low must not land.
		ce <= 1'b0;
		reg_wr(4'h1, 32'h0000_0055);
		ce <= 1'b1;
		reg_rd(4'h1, 32'hFFFF_FFFF, 32'h0000_0080);
		// Let the last answer reach the checker before the verdict.
		repeat (2) @(posedge clk);
		close_out;
	end
endmodule
